// ==== shared/fcd_pkg.sv ====
// =====================================================================
// Shared constants of the coefficient download block.
package fcd_pkg;

    // =================================================================
    // Bus register byte offsets.
    localparam logic [4:0] FCD_OFS_PORT   = 5'h00;
    localparam logic [4:0] FCD_OFS_STATUS = 5'h04;
    localparam logic [4:0] FCD_OFS_CTRL1  = 5'h08;
    localparam logic [4:0] FCD_OFS_ISTS   = 5'h0c;
    localparam logic [4:0] FCD_OFS_IMASK  = 5'h10;
    localparam logic [4:0] FCD_OFS_CIDX   = 5'h14;
    localparam logic [4:0] FCD_OFS_CDATA  = 5'h18;

    // =================================================================
    // Word stream: register address words and control field positions.
    localparam logic [15:0] FCD_CTRL1_ADDR   = 16'h0001;
    localparam int          FCD_REQ_BIT      = 15;
    localparam int          FCD_TAP_HI       = 8;
    localparam int          FCD_TAP_LO       = 5;
    localparam logic [8:0]  FCD_CTRL1_RESET  = 9'h01a;
    localparam int          FCD_VERIFIED_BIT = 7;

    // =================================================================
    // Coefficient format and storage.
    localparam int FCD_COEF_W    = 27;
    localparam int FCD_HI_W      = 11;
    localparam int FCD_NUM_SLOTS = 48;
    localparam int FCD_IDX_W     = 6;
    localparam logic [5:0] FCD_COEF_STEP = 6'h06;

    // =================================================================
    // Interrupt status bit positions.
    localparam int FCD_IRQ_OK   = 0;
    localparam int FCD_IRQ_FAIL = 1;

    // =================================================================
    // Zero fill pacing: half a divided core clock period per slot.
    localparam int FCD_CLK_PERIOD_PS  = 5000;
    localparam int FCD_DIVIDED_CORE_CLOCK_PERIOD_PS = 10000;
    localparam int FCD_FILL_PS        = FCD_DIVIDED_CORE_CLOCK_PERIOD_PS / 2;
    localparam int FCD_FILL_CYC_RAW   =
        (FCD_FILL_PS + FCD_CLK_PERIOD_PS - 1) / FCD_CLK_PERIOD_PS;
    localparam int FCD_FILL_CYC = (FCD_FILL_CYC_RAW < 1) ? 1
                                                         : FCD_FILL_CYC_RAW;
    localparam logic [3:0] FCD_FILL_RELOAD = 4'(FCD_FILL_CYC - 1);

endpackage

// ==== shared/fcd_coef_if.sv ====
`timescale 1ns/100ps
// =====================================================================
// Write and read path between the loader and the coefficient store.
interface fcd_coef_if;
    logic                            we;
    logic [fcd_pkg::FCD_IDX_W-1:0]   waddr;
    logic [fcd_pkg::FCD_COEF_W-1:0] wdata;
    logic [fcd_pkg::FCD_IDX_W-1:0]   raddr;
    logic [fcd_pkg::FCD_COEF_W-1:0] rdata;

    modport ctl (output we, output waddr, output wdata, output raddr,
                 input rdata);
    modport mem (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface

// ==== logic/fcd_coef_mem.sv ====
`timescale 1ns/100ps
// =====================================================================
// Volatile coefficient store with registered read data.
module fcd_coef_mem (
    // Clock and reset.
    input  wire logic  clock,
    input  wire logic  reset,
    // Store access.
    fcd_coef_if.mem    port
);

    typedef struct packed {
        logic [fcd_pkg::FCD_NUM_SLOTS-1:0][fcd_pkg::FCD_COEF_W-1:0] arr;
        logic [fcd_pkg::FCD_COEF_W-1:0]                           rd;
    } fcd_mem_s;

    fcd_mem_s r;
    fcd_mem_s nxt;

    // Writes one slot and registers the addressed slot for reading.
    always_comb begin
        nxt = r;
        if (port.we && (int'(port.waddr) < fcd_pkg::FCD_NUM_SLOTS)) begin
            nxt.arr[port.waddr] = port.wdata;
        end
        if (int'(port.raddr) < fcd_pkg::FCD_NUM_SLOTS) begin
            nxt.rd = r.arr[port.raddr];
        end else begin
            nxt.rd = '0;
        end
    end

    // The array is wiped by the loader's sweep, so only read data resets.
    always_ff @(posedge clock) begin
        r <= nxt;
        if (reset) begin
            r.rd <= '0;
        end
    end

    assign port.rdata = r.rd;

endmodule

// ==== logic/fcd_loader.sv ====
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
// =====================================================================
// Coefficient download engine with an Avalon-MM register slave.
module fcd_loader (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        reset,
    // Avalon-MM slave.
    input  wire logic [4:0]  address,
    input  wire logic [3:0]  byteenable,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Interrupt.
    output logic             irq,
    // Filter side outputs.
    output logic             load_verified_flag,
    output logic             user_filter_active,
    output logic [3:0]       tap_count_select
);

    // =================================================================
    // State.
    typedef enum logic [2:0] {
        ST_ADDR,
        ST_DATA,
        ST_HI,
        ST_LO,
        ST_SUM,
        ST_FILL
    } fcd_state_e;

    typedef struct packed {
        fcd_state_e  st;
        logic        wreq;
        logic [31:0] rdata;
        logic [15:0] addr_word;
        logic [8:0]  ctrl;
        logic [5:0]  ncoef;
        logic [5:0]  idx;
        logic [10:0] hi;
        logic [15:0] sum;
        logic [3:0]  cnt;
        logic        verified;
        logic        user;
        logic [1:0]  ists;
        logic [1:0]  imask;
        logic        irq;
        logic [5:0]  cidx;
        logic        we;
        logic [5:0]  waddr;
        logic [26:0] wdata;
    } fcd_loader_s;

    fcd_loader_s r;
    fcd_loader_s nxt;

    fcd_coef_if cif ();

    fcd_coef_mem u_mem (
        .clock (clock),
        .reset (reset),
        .port  (cif.mem)
    );

    logic        acc_wr;
    logic        port_wr;
    logic [15:0] word;
    logic [15:0] word_sum;
    logic [3:0]  code;
    logic [1:0]  ev;
    logic [1:0]  w1c;

    // =================================================================
    // Decode of the bus request that completes in this cycle.
    always_comb begin
        acc_wr   = write && !r.wreq;
        word     = writedata[15:0];
        port_wr  = acc_wr && (address[4:2] == fcd_pkg::FCD_OFS_PORT[4:2])
                   && (byteenable[1:0] == 2'h3);
        word_sum = 16'(r.sum + {8'h00, word[15:8]} + {8'h00, word[7:0]});
        code     = word[fcd_pkg::FCD_TAP_HI:fcd_pkg::FCD_TAP_LO];
    end

    // =================================================================
    // Next state of the whole block.
    always_comb begin
        nxt    = r;
        nxt.we = 1'b0;
        ev     = 2'h0;
        w1c    = 2'h0;

        // Bus handshake: answer one cycle after the request is seen; a port write waits out the zero fill.
        if (!r.wreq) begin
            nxt.wreq = 1'b1;
        end else if (read || (write && !(r.st == ST_FILL
                 && address[4:2] == fcd_pkg::FCD_OFS_PORT[4:2]))) begin
            nxt.wreq  = 1'b0;
            nxt.rdata = 32'h0;
            case (address[4:2])
                fcd_pkg::FCD_OFS_STATUS[4:2]: begin
                    nxt.rdata[fcd_pkg::FCD_VERIFIED_BIT] = r.verified;
                    nxt.rdata[1] = r.user;
                    nxt.rdata[0] = (r.st == ST_FILL);
                end
                fcd_pkg::FCD_OFS_CTRL1[4:2]: nxt.rdata = {23'h0, r.ctrl};
                fcd_pkg::FCD_OFS_ISTS[4:2]:  nxt.rdata = {30'h0, r.ists};
                fcd_pkg::FCD_OFS_IMASK[4:2]: nxt.rdata = {30'h0, r.imask};
                fcd_pkg::FCD_OFS_CIDX[4:2]:  nxt.rdata = {26'h0, r.cidx};
                fcd_pkg::FCD_OFS_CDATA[4:2]: nxt.rdata = {5'h0, cif.rdata};
                default:                     nxt.rdata = 32'h0;
            endcase
        end

        // Plain register writes at the completing edge.
        if (acc_wr && byteenable[0]) begin
            case (address[4:2])
                fcd_pkg::FCD_OFS_ISTS[4:2]:  w1c = writedata[1:0];
                fcd_pkg::FCD_OFS_IMASK[4:2]: nxt.imask = writedata[1:0];
                fcd_pkg::FCD_OFS_CIDX[4:2]:  nxt.cidx = writedata[5:0];
                default:                     ;
            endcase
        end

        // Word stream of the parallel port.
        case (r.st)
            ST_ADDR: begin
                if (port_wr) begin
                    nxt.addr_word = word;
                    nxt.st        = ST_DATA;
                end
            end
            ST_DATA: begin
                if (port_wr) begin
                    nxt.st = ST_ADDR;
                    if (r.addr_word == fcd_pkg::FCD_CTRL1_ADDR) begin
                        nxt.ctrl = word[8:0];
                        if (word[fcd_pkg::FCD_REQ_BIT]) begin
                            nxt.verified = 1'b0;
                            nxt.user     = 1'b0;
                            if (code[0]) begin
                                // Odd codes select six coefficients per step.
                                nxt.ncoef = 6'(({3'h0, code[3:1]} + 6'h01)
                                               * fcd_pkg::FCD_COEF_STEP);
                                nxt.idx = 6'h00;
                                nxt.sum = 16'h0000;
                                nxt.st  = ST_HI;
                            end
                        end
                    end
                end
            end
            ST_HI: begin
                if (port_wr) begin
                    // Top five bits are padding; sign and magnitude kept.
                    nxt.hi  = word[10:0];
                    nxt.sum = word_sum;
                    nxt.st  = ST_LO;
                end
            end
            ST_LO: begin
                if (port_wr) begin
                    nxt.we    = 1'b1;
                    nxt.waddr = r.idx;
                    nxt.wdata = {r.hi, word};
                    nxt.sum   = word_sum;
                    if (r.idx == 6'(r.ncoef - 6'h01)) begin
                        nxt.st = ST_SUM;
                    end else begin
                        nxt.idx = 6'(r.idx + 6'h01);
                        nxt.st  = ST_HI;
                    end
                end
            end
            ST_SUM: begin
                if (port_wr) begin
                    if (word == r.sum) begin
                        nxt.verified = 1'b1;
                        nxt.user     = 1'b1;
                        ev[fcd_pkg::FCD_IRQ_OK] = 1'b1;
                    end else begin
                        nxt.verified = 1'b0;
                        ev[fcd_pkg::FCD_IRQ_FAIL] = 1'b1;
                    end
                    nxt.idx = r.ncoef;
                    nxt.cnt = fcd_pkg::FCD_FILL_RELOAD;
                    nxt.st  = (int'(r.ncoef) == fcd_pkg::FCD_NUM_SLOTS)
                              ? ST_ADDR : ST_FILL;
                end
            end
            ST_FILL: begin
                if (r.cnt == 4'h0) begin
                    nxt.we    = 1'b1;
                    nxt.waddr = r.idx;
                    nxt.wdata = 27'h0;
                    nxt.cnt   = fcd_pkg::FCD_FILL_RELOAD;
                    if (int'(r.idx) == fcd_pkg::FCD_NUM_SLOTS - 1) begin
                        nxt.st = ST_ADDR;
                    end else begin
                        nxt.idx = 6'(r.idx + 6'h01);
                    end
                end else begin
                    nxt.cnt = 4'(r.cnt - 4'h1);
                end
            end
            default: nxt.st = ST_ADDR;
        endcase

        // Sticky status: a new event wins over a clear in the same cycle.
        nxt.ists = (r.ists & ~w1c) | ev;
        nxt.irq  = |(r.ists & r.imask);
    end

    // =================================================================
    // State register; reset sweeps every slot back to zero.
    always_ff @(posedge clock) begin
        if (reset) begin
            r          <= '0;
            r.st       <= ST_FILL;
            r.wreq     <= 1'b1;
            r.ctrl     <= fcd_pkg::FCD_CTRL1_RESET;
            r.ncoef    <= 6'h00;
            r.cnt      <= fcd_pkg::FCD_FILL_RELOAD;
        end else begin
            r <= nxt;
        end
    end

    // =================================================================
    // Store connections and outputs.
    assign cif.we             = r.we;
    assign cif.waddr          = r.waddr;
    assign cif.wdata          = r.wdata;
    assign cif.raddr          = r.cidx;
    assign readdata           = r.rdata;
    assign waitrequest        = r.wreq;
    assign irq                = r.irq;
    assign load_verified_flag = r.verified;
    assign user_filter_active = r.user;
    assign tap_count_select   = r.ctrl[8:5];

    // =================================================================
    // Checks.
    AST_SUM_PASS: assert property (@(posedge clock) disable iff (reset)
        (r.st == ST_SUM && port_wr && word == r.sum)
        |=> (r.verified && r.ists[fcd_pkg::FCD_IRQ_OK]))
        else $error("Matching checksum did not set the flag.");

    AST_SUM_FAIL: assert property (@(posedge clock) disable iff (reset)
        (r.st == ST_SUM && port_wr && word != r.sum)
        |=> (!r.verified && r.ists[fcd_pkg::FCD_IRQ_FAIL]))
        else $error("Bad checksum left the flag set.");

    AST_FILL_STEP: assert property (@(posedge clock) disable iff (reset)
        (r.st == ST_FILL && r.cnt == 4'h0 && int'(r.idx) < 47)
        |=> (r.we && r.wdata == 27'h0 && r.idx == $past(r.idx) + 6'h01))
        else $error("Zero fill did not advance one slot.");

    AST_RESET_SWEEP: assert property (@(posedge clock)
        $fell(reset) |-> (r.st == ST_FILL && r.idx == 6'h00))
        else $error("Reset did not start the clearing sweep.");

    AST_BYTE_SUM: assert property (@(posedge clock) disable iff (reset)
        (r.st == ST_HI && port_wr)
        |=> (r.sum == 16'($past(r.sum) + $past(word[15:8])
                          + $past(word[7:0]))))
        else $error("Checksum did not add both bytes.");

    AST_TAP_DECODE: assert property (@(posedge clock) disable iff (reset)
        (r.st == ST_DATA && port_wr && r.addr_word == 16'h0001
         && word[15] && word[5])
        |=> (r.st == ST_HI && r.ncoef == 6'(6 * (int'($past(word[8:6])) + 1))))
        else $error("Tap code decoded to the wrong count.");

    AST_PAIR_WRITE: assert property (@(posedge clock) disable iff (reset)
        (r.st == ST_LO && port_wr)
        |=> (r.we && r.wdata[15:0] == $past(word)
             && r.wdata[26:16] == r.hi))
        else $error("Coefficient halves assembled wrongly.");

    AST_ONE_ANSWER: assert property (@(posedge clock) disable iff (reset)
        !waitrequest |=> waitrequest)
        else $error("Wait request stayed low two cycles.");

    AST_STREAM_STALL: assert property (@(posedge clock) disable iff (reset)
        (r.st == ST_FILL && write && address[4:2] == 3'h0) |=> waitrequest)
        else $error("Port write accepted during zero fill.");

endmodule

// ==== sim/fcd_host.sv ====
`timescale 1ns/100ps
// =====================================================================
// Host model: an Avalon-MM master that streams words to the loader.
module fcd_host (
    // Clock.
    input  wire logic        clock,
    // Avalon-MM master.
    output logic      [4:0]  address,
    output logic      [3:0]  byteenable,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest
);
    // Coefficients to send and last read data.
    logic [26:0] coef [48];
    logic [31:0] rd_q;

    // The bus idles from time zero.
    initial begin
        address    = 5'h00;
        byteenable = 4'hf;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h0;
    end

    // One bus cycle, held until waitrequest is sampled low.
    // Only the bench watchdog ends a wait that never gets an answer.
    task automatic xfer(input logic rd, input logic [4:0] a,
                        input logic [31:0] d);
        @(posedge clock);
        address   <= a;
        read      <= rd;
        write     <= !rd;
        writedata <= d;
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        rd_q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    // One stream word to the parallel port.
    task automatic word(input logic [15:0] w);
        xfer(1'b0, fcd_pkg::FCD_OFS_PORT, {16'h0, w});
    endtask

    // Control register 1: address word, then one data word.
    task automatic ctrl(input logic [15:0] v);
        word(fcd_pkg::FCD_CTRL1_ADDR); // Address first.
        word(v);
    endtask

    // A whole download, then a wait until the zero fill is over.
    task automatic load(input logic [15:0] v, input int n,
                        input logic [15:0] sum);
        int k;
        ctrl(v); // Request and tap field together.
        for (int i = 0; i < n; i++) begin
            word({5'h00, coef[i][26:16]}); // Upper half.
            word(coef[i][15:0]); // Lower half next.
        end
        word(sum); // Checksum right after.
        k = 0;
        do begin
            xfer(1'b1, fcd_pkg::FCD_OFS_STATUS, 32'h0); // Wait.
            k++;
        end while (rd_q[0] !== 1'b0 && k < 200);
    endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
// =====================================================================
// Self-checking bench for the coefficient download engine.
module tb_top;
    logic        clock;
    logic        reset;
    logic [4:0]  address;
    logic [3:0]  byteenable;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        irq;
    logic        load_verified_flag;
    logic        user_filter_active;
    logic [3:0]  tap_count_select;
    int          num_errors;
    int          n_checks;
    integer      seed;
    logic [3:0]  code;
    int          n;
    localparam logic [4:0] a_sts = fcd_pkg::FCD_OFS_STATUS;
    localparam logic [4:0] a_ctl = fcd_pkg::FCD_OFS_CTRL1;
    localparam logic [4:0] a_ist = fcd_pkg::FCD_OFS_ISTS;
    localparam logic [4:0] a_msk = fcd_pkg::FCD_OFS_IMASK;
    // Words of the 12-tap worked example, upper then lower.
    logic [15:0] ex_w [24] = '{16'h032b, 16'h9688, 16'h01bf, 16'h183c,
        16'h0015, 16'h6626, 16'h04a8, 16'h1e6a, 16'h045f, 16'h2a96,
        16'h002c, 16'h49c2, 16'h0050, 16'he9f6, 16'h0010, 16'hdbd8,
        16'h042f, 16'hde54, 16'h0437, 16'h445a, 16'h041b, 16'h7d6e,
        16'h0404, 16'h3b5f};

    // Host model and design.
    fcd_host host_u (.clock(clock), .address(address),
        .byteenable(byteenable), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest));
    fcd_loader dut_u (.clock(clock), .reset(reset), .address(address),
        .byteenable(byteenable), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq),
        .load_verified_flag(load_verified_flag),
        .user_filter_active(user_filter_active),
        .tap_count_select(tap_count_select));

    // Free-running 200 MHz clock.
    always #2.5 clock = ~clock;

    // Compares one value and counts the outcome.
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Reads a register and compares it.
    task automatic rchk(input string nm, input logic [4:0] a,
                        input logic [31:0] exp);
        host_u.xfer(1'b1, a, 32'h0);
        chk(nm, host_u.rd_q, exp);
    endtask

    // Reads back one stored coefficient.
    task automatic slot(input int i, input logic [26:0] exp);
        host_u.xfer(1'b0, fcd_pkg::FCD_OFS_CIDX, 32'(i));
        rchk("coef", fcd_pkg::FCD_OFS_CDATA, {5'h00, exp});
    endtask

    // Byte sum over the four bytes of each padded coefficient.
    function automatic logic [15:0] csum(input int n);
        logic [15:0] s;
        logic [31:0] w;
        s = 16'h0;
        for (int i = 0; i < n; i++) begin
            w = {5'h00, host_u.coef[i]};
            s = s + w[31:24] + w[23:16] + w[15:8] + w[7:0];
        end
        return s;
    endfunction

    // Flags, tap field and stored slots after a download.
    task automatic check_load(input int n, input logic ok,
                              input logic [3:0] c);
        rchk("status", a_sts, {24'h0, ok, 5'h00, ok, 1'b0});
        chk("verified", 32'(load_verified_flag), 32'(ok));
        chk("active", 32'(user_filter_active), 32'(ok));
        chk("taps", 32'(tap_count_select), 32'(c));
        if (ok) begin
            slot(0, host_u.coef[0]);
            slot(n - 1, host_u.coef[n - 1]);
            if (n < 48)
                slot(n, 27'h0);
        end
    endtask

    // State after reset and the clearing sweep.
    task automatic check_reset();
        repeat (60) @(posedge clock);
        chk("rst_out", {irq, load_verified_flag, user_filter_active,
            tap_count_select}, 32'h00);
        rchk("ctrl1", a_ctl, 32'h01a);
        slot(0, 27'h0);
        slot(47, 27'h0);
    endtask

    // Loads the worked example, whose checksum is known.
    task automatic load_example();
        for (int i = 0; i < 12; i++)
            host_u.coef[i] = {ex_w[2 * i][10:0], ex_w[2 * i + 1]};
        host_u.load(16'h8079, 12, 16'h0e6b);
        check_load(12, 1'b1, 4'h3);
        chk("irq", 32'(irq), 32'h1);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (40000) @(posedge clock);
        num_errors++;
        report_and_stop();
    end

    // Main sequence.
    initial begin
        clock      = 1'b0;
        reset      = 1'b1;
        seed       = 9079;
        num_errors = 0;
        n_checks   = 0;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        check_reset();
        host_u.xfer(1'b0, 5'h1c, 32'hffff);
        rchk("unmapped", 5'h1c, 32'h0);
        host_u.xfer(1'b0, a_msk, 32'h3);
        load_example();
        // A control write without the request bit reads back and keeps the filter.
        host_u.ctrl(16'h0879);
        rchk("ctrl1", a_ctl, 32'h079);
        check_load(12, 1'b1, 4'h3);
        host_u.xfer(1'b0, a_ist, 32'h1);
        // Every odd tap code, longest first, so fill must clear slots.
        for (int c = 7; c >= 0; c--) begin
            code = 4'(2 * c + 1);
            n = 6 * (c + 1);
            for (int i = 0; i < n; i++)
                host_u.coef[i] = 27'($random(seed));
            host_u.load({1'b1, 6'h00, code, 5'h19}, n, csum(n));
            check_load(n, 1'b1, code);
            chk("irq", 32'(irq), 32'h1);
            host_u.xfer(1'b0, a_ist, 32'h1);
            rchk("ists", a_ist, 32'h0);
            chk("irq", 32'(irq), 32'h0);
        end
        // Wrong checksum while masked, then unmask and clear.
        host_u.xfer(1'b0, a_msk, 32'h0);
        for (int i = 0; i < 6; i++)
            host_u.coef[i] = 27'($random(seed));
        host_u.load(16'h8039, 6, csum(6) + 16'h1);
        check_load(6, 1'b0, 4'h1);
        rchk("ists", a_ist, 32'h2);
        chk("irq", 32'(irq), 32'h0);
        host_u.xfer(1'b0, a_msk, 32'h3);
        rchk("imask", a_msk, 32'h3);
        chk("irq", 32'(irq), 32'h1);
        host_u.xfer(1'b0, a_ist, 32'h2);
        rchk("ists", a_ist, 32'h0);
        chk("irq", 32'(irq), 32'h0);
        // Even and zero codes select the default filter.
        host_u.ctrl(16'h8059);
        check_load(0, 1'b0, 4'h2);
        host_u.ctrl(16'h8019);
        check_load(0, 1'b0, 4'h0);
        // A data word aimed at another register starts nothing.
        host_u.word(16'h0002);
        host_u.word(16'h81f9);
        rchk("ctrl1", a_ctl, 32'h019);
        chk("taps", 32'(tap_count_select), 32'h0);
        // Reset in mid-run discards the loaded filter.
        load_example();
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        // A port word during the clearing sweep waits for its end.
        host_u.word(16'h0002);
        rchk("fill", a_sts, 32'h0);
        check_reset();
        report_and_stop();
    end
endmodule
